// ==== pst_pkg.sv ====
package pst_pkg;
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          TMR_W         = 18;
  localparam int          CNT_W         = 4;
  localparam int          SYNC_W        = 5;
  // Synchronised pin vector positions
  localparam int          PIN_PON       = 0;
  localparam int          PIN_TRIAL     = 1;
  localparam int          PIN_OVLO      = 2;
  localparam int          PIN_TSD       = 3;
  localparam int          PIN_VIN_OK    = 4;
  // Times in ns, cycle counts rounded up (least times)
  localparam int          OFF_TIMER_NS  = 500_000;
  localparam int          ST_GAP_NS     = 2_000_000;
  localparam int          HOLD_LOW_NS   = 1_000_000;
  localparam int          OVLO_DBNC_NS  = 10_000;
  localparam int          OFF_TIMER_CYC =
    (OFF_TIMER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          ST_GAP_CYC    =
    (ST_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          HOLD_LOW_CYC  =
    (HOLD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          OVLO_DBNC_CYC =
    (OVLO_DBNC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0]  ST_MAX_TRIES  = 2'h3;
  localparam logic [CNT_W-1:0] FAILSAFE_EVENT_COUNT_RST = 4'h0;
  localparam logic [TMR_W-1:0] TMR_RST    = 18'h0_0000;

  typedef enum logic [8:0] {
    PST_LOW_POWER_OFF_STATE     = 9'h0_001,
    PST_SELF_TEST  = 9'h0_002,
    PST_QUICK_START_OFF_STATE    = 9'h0_004,
    PST_PWR_UP     = 9'h0_008,
    PST_SYS_ON     = 9'h0_010,
    PST_PD_TURNOFF = 9'h0_020,
    PST_PD_FAULT   = 9'h0_040,
    PST_FS_TRANS   = 9'h0_080,
    PST_FS_LOCK    = 9'h0_100
  } pst_state_t;
endpackage

// ==== pst_power_state_transitions.sv ====
`timescale 1ns/1ps
// What this block does
// - Latched event, check passed, selection 0: pass through to power-up
// - Selection 1, level mode: power-up on power-on high, conditions valid
// - Selection 1, edge mode: power-up on falling edge, conditions valid
// - Trial pin high: same level or edge power-up from quick-start off
// - Enter system-on when power-up sequence releases the host reset
// - Level mode in system-on: power-on low starts turn-off
// - Edge mode: fall then low past hold-low time starts turn-off
// - Software off request starts turn-off after 500 us timer expires
// - Enabled overvoltage past debounce: protective turn-off, not a fault
// - Fault timer expiry in system-on enters fault power-down
// - Fault count equal to limit in system-on enters fault power-down
// - Thermal shutdown in system-on enters fault power-down
// - Finished turn-off power-down goes straight to low-power off
// - Failure during power-up goes to fault power-down
// - Three self-check failures, trial pin low: fail-safe transition
// - Finished fault power-down goes to fail-safe transition
// - Fail-safe return to low-power off if count below limit or bypass
// - Count at limit without bypass locks in fail-safe state
// - Power-up event ignored in quick-start off while any error flag set
// - Self-check attempted up to three times (two retries), 2 ms apart
module pst_power_state_transitions
  import pst_pkg::*;
#(
  parameter logic [TMR_W-1:0] OFF_CYC  = TMR_W'(OFF_TIMER_CYC),
  parameter logic [TMR_W-1:0] GAP_CYC  = TMR_W'(ST_GAP_CYC),
  parameter logic [TMR_W-1:0] HOLD_CYC = TMR_W'(HOLD_LOW_CYC),
  parameter logic [TMR_W-1:0] DBNC_CYC = TMR_W'(OVLO_DBNC_CYC)
) (
  input  wire logic             core_clk_in,          // 100 MHz clock
  input  wire logic             arst_n_in,            // Async reset, low
  input  wire logic             power_on_input_in,    // Power-on pin
  input  wire logic             config_trial_mode_pin_in, // Trial pin
  input  wire logic             input_overvoltage_lockout_in, // OV comp
  input  wire logic             thermal_shutdown_limit_in, // Tj above
  input  wire logic             vin_in_window_in,     // VIN valid window
  input  wire logic             low_power_off_select_in, // Off select
  input  wire logic             power_on_edge_mode_in, // 1 = edge mode
  input  wire logic             overvoltage_shutdown_enable_in, // OV en
  input  wire logic             trim_load_error_in,   // Trim error
  input  wire logic             fuse_load_error_in,   // Fuse error
  input  wire logic             software_off_request_in, // Off request
  input  wire logic             fault_timer_expired_in, // Fault timer
  input  wire logic [CNT_W-1:0] fault_event_count_in, // Fault count
  input  wire logic [CNT_W-1:0] fault_count_limit_in, // Fault limit
  input  wire logic [CNT_W-1:0] failsafe_count_limit_in, // FS limit
  input  wire logic             failsafe_lock_bypass_in, // FS bypass
  input  wire logic             self_check_done_in,   // Check finished
  input  wire logic             self_check_ok_in,     // Check passed
  input  wire logic             host_reset_release_in, // Seq releases
  input  wire logic             power_up_failure_in,  // Seq failure
  input  wire logic             power_down_done_in,   // Down seq done
  output logic [8:0]            state_out,            // One-hot state
  output logic                  self_check_start_out, // Check pulse
  output logic                  self_check_fail_out,  // Sticky failure
  output logic                  host_reset_output_n_out, // Host reset
  output logic [CNT_W-1:0]      failsafe_event_count_out, // FS count
  output logic                  turnoff_protective_out // Last was OV
);

  pst_state_t             state_q, state_d;
  logic [SYNC_W-1:0]      meta_q, sync_q;
  logic                   pon_prev_q;
  logic                   evt_q, evt_d;
  logic [1:0]             tries_q, tries_d;
  logic                   gap_act_q, gap_act_d;
  logic                   start_q, start_d;
  logic                   stfail_q, stfail_d;
  logic                   rst_n_q, rst_n_d;
  logic                   armed_q, armed_d;
  logic                   prot_q, prot_d;
  logic [CNT_W-1:0]       failsafe_event_count_q, failsafe_event_count_d;
  logic [TMR_W-1:0]       off_tmr_q, off_tmr_d;
  logic [TMR_W-1:0]       hold_tmr_q, hold_tmr_d;
  logic [TMR_W-1:0]       ovlo_tmr_q, ovlo_tmr_d;
  logic [TMR_W-1:0]       gap_tmr_q, gap_tmr_d;
  logic                   pon, fall, trial, ovlo, thermal_shutdown_limit, vin_ok;
  logic                   errs, env_ok, fault_cause, off_cause;
  logic                   off_exp, hold_exp, ovlo_exp;

  function automatic logic pwr_evt(input logic edge_mode,
                                   input logic level,
                                   input logic falling);
    pwr_evt = edge_mode ? falling : level;
  endfunction

  // Pins come from outside the clock domain
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
        end else begin
          meta_q[gi] <= (gi == PIN_PON)    ? power_on_input_in :
                        (gi == PIN_TRIAL)  ? config_trial_mode_pin_in :
                        (gi == PIN_OVLO)   ? input_overvoltage_lockout_in :
                        (gi == PIN_TSD)    ? thermal_shutdown_limit_in :
                                             vin_in_window_in;
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  assign pon    = sync_q[PIN_PON];
  assign fall   = pon_prev_q & ~pon;
  assign trial  = sync_q[PIN_TRIAL];
  assign ovlo   = sync_q[PIN_OVLO];
  assign thermal_shutdown_limit    = sync_q[PIN_TSD];
  assign vin_ok = sync_q[PIN_VIN_OK];
  assign errs   = trim_load_error_in | fuse_load_error_in | stfail_q;
  assign env_ok = vin_ok & ~thermal_shutdown_limit;
  assign off_exp  = (off_tmr_q == OFF_CYC);
  assign hold_exp = (hold_tmr_q > HOLD_CYC);
  assign ovlo_exp = (ovlo_tmr_q > DBNC_CYC);
  assign fault_cause = fault_timer_expired_in | thermal_shutdown_limit |
                       (fault_event_count_in == fault_count_limit_in);
  assign off_cause = (~power_on_edge_mode_in & ~pon) |
                     (power_on_edge_mode_in & hold_exp) |
                     (software_off_request_in & off_exp) |
                     (overvoltage_shutdown_enable_in & ovlo_exp);

  // System-on timers
  always_comb begin
    off_tmr_d  = TMR_RST;
    hold_tmr_d = TMR_RST;
    ovlo_tmr_d = TMR_RST;
    armed_d    = 1'b0;
    if (state_q == PST_SYS_ON) begin
      if (software_off_request_in) begin
        off_tmr_d = off_exp ? off_tmr_q : off_tmr_q + 1'b1;
      end
      armed_d = power_on_edge_mode_in & ~pon & (armed_q | fall);
      if (armed_q && !pon) begin
        hold_tmr_d = hold_exp ? hold_tmr_q : hold_tmr_q + 1'b1;
      end
      if (ovlo) begin
        ovlo_tmr_d = ovlo_exp ? ovlo_tmr_q : ovlo_tmr_q + 1'b1;
      end
    end
  end

  // Main transition logic
  always_comb begin
    state_d   = state_q;
    evt_d     = evt_q;
    tries_d   = tries_q;
    gap_act_d = 1'b0;
    gap_tmr_d = TMR_RST;
    start_d   = 1'b0;
    stfail_d  = stfail_q;
    rst_n_d   = rst_n_q;
    prot_d    = prot_q;
    failsafe_event_count_d  = failsafe_event_count_q;
    case (state_q)
      PST_LOW_POWER_OFF_STATE: begin
        rst_n_d = 1'b0;
        if (low_power_off_select_in || trial) begin
          state_d = PST_SELF_TEST;
          evt_d   = 1'b0;
        end else if (pwr_evt(power_on_edge_mode_in, pon, fall) && env_ok &&
                     !trim_load_error_in && !fuse_load_error_in) begin
          state_d = PST_SELF_TEST;
          evt_d   = 1'b1;
        end
        if (state_d == PST_SELF_TEST) begin
          start_d  = 1'b1;
          tries_d  = 2'h0;
          stfail_d = 1'b0;
        end
      end
      PST_SELF_TEST: begin
        if (gap_act_q) begin
          // Settling gap before the next attempt
          gap_act_d = 1'b1;
          gap_tmr_d = gap_tmr_q + 1'b1;
          if (gap_tmr_q == GAP_CYC) begin
            gap_act_d = 1'b0;
            gap_tmr_d = TMR_RST;
            start_d   = 1'b1;
          end
        end else if (self_check_done_in && !start_q) begin
          if (self_check_ok_in) begin
            state_d = PST_QUICK_START_OFF_STATE;
          end else if (tries_q + 2'h1 == ST_MAX_TRIES) begin
            stfail_d = 1'b1;
            evt_d    = 1'b0;
            // Trial mode parks in quick-start off for debug access
            state_d  = trial ? PST_QUICK_START_OFF_STATE : PST_FS_TRANS;
          end else begin
            tries_d   = tries_q + 2'h1;
            gap_act_d = 1'b1;
          end
        end
      end
      PST_QUICK_START_OFF_STATE: begin
        if (errs) begin
          evt_d = 1'b0;
        end else if (evt_q && !low_power_off_select_in && !trial) begin
          state_d = PST_PWR_UP;
        end else if ((low_power_off_select_in || trial) && env_ok &&
                     pwr_evt(power_on_edge_mode_in, pon, fall)) begin
          state_d = PST_PWR_UP;
        end
        if (state_d == PST_PWR_UP) begin
          evt_d = 1'b0;
        end
      end
      PST_PWR_UP: begin
        if (power_up_failure_in) begin
          state_d = PST_PD_FAULT;
        end else if (host_reset_release_in) begin
          state_d = PST_SYS_ON;
          rst_n_d = 1'b1;
        end
      end
      PST_SYS_ON: begin
        if (fault_cause) begin
          state_d = PST_PD_FAULT;
          rst_n_d = 1'b0;
          prot_d  = 1'b0;
        end else if (off_cause) begin
          state_d = PST_PD_TURNOFF;
          rst_n_d = 1'b0;
          prot_d  = overvoltage_shutdown_enable_in & ovlo_exp;
        end
      end
      PST_PD_TURNOFF: begin
        if (power_down_done_in) begin
          state_d = PST_LOW_POWER_OFF_STATE;
        end
      end
      PST_PD_FAULT: begin
        rst_n_d = 1'b0;
        if (power_down_done_in) begin
          state_d = PST_FS_TRANS;
        end
      end
      PST_FS_TRANS: begin
        if (failsafe_lock_bypass_in ||
            failsafe_event_count_q < failsafe_count_limit_in) begin
          state_d = PST_LOW_POWER_OFF_STATE;
          // Saturate at all ones so the counter never wraps back to zero
          if (failsafe_event_count_q != {CNT_W{1'b1}}) begin
            failsafe_event_count_d = failsafe_event_count_q + 1'b1;
          end
        end else begin
          state_d = PST_FS_LOCK;
        end
      end
      PST_FS_LOCK: begin
        rst_n_d = 1'b0;
      end
      default: begin
        state_d = PST_LOW_POWER_OFF_STATE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q    <= PST_LOW_POWER_OFF_STATE;
      pon_prev_q <= 1'b0;
      evt_q      <= 1'b0;
      tries_q    <= 2'h0;
      gap_act_q  <= 1'b0;
      gap_tmr_q  <= TMR_RST;
      start_q    <= 1'b0;
      stfail_q   <= 1'b0;
      rst_n_q    <= 1'b0;
      prot_q     <= 1'b0;
      failsafe_event_count_q   <= FAILSAFE_EVENT_COUNT_RST;
      off_tmr_q  <= TMR_RST;
      hold_tmr_q <= TMR_RST;
      ovlo_tmr_q <= TMR_RST;
      armed_q    <= 1'b0;
    end else begin
      state_q    <= state_d;
      pon_prev_q <= pon;
      evt_q      <= evt_d;
      tries_q    <= tries_d;
      gap_act_q  <= gap_act_d;
      gap_tmr_q  <= gap_tmr_d;
      start_q    <= start_d;
      stfail_q   <= stfail_d;
      rst_n_q    <= rst_n_d;
      prot_q     <= prot_d;
      failsafe_event_count_q   <= failsafe_event_count_d;
      off_tmr_q  <= off_tmr_d;
      hold_tmr_q <= hold_tmr_d;
      ovlo_tmr_q <= ovlo_tmr_d;
      armed_q    <= armed_d;
    end
  end

  assign state_out                = state_q;
  assign self_check_start_out     = start_q;
  assign self_check_fail_out      = stfail_q;
  assign host_reset_output_n_out  = rst_n_q;
  assign failsafe_event_count_out = failsafe_event_count_q;
  assign turnoff_protective_out   = prot_q;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);

  property p_fault_first;
    state_q == PST_SYS_ON && fault_cause |=> state_q == PST_PD_FAULT;
  endproperty
  a_fault_first: assert property (p_fault_first)
    else $error("fault cause did not win");
  property p_pwrup_fail;
    state_q == PST_PWR_UP && power_up_failure_in |=> state_q == PST_PD_FAULT;
  endproperty
  a_pwrup_fail: assert property (p_pwrup_fail)
    else $error("power-up failure ignored");
  property p_sys_on_entry;
    state_q != PST_SYS_ON ##1 state_q == PST_SYS_ON |->
      rst_n_q && $past(host_reset_release_in);
  endproperty
  a_sys_on_entry: assert property (p_sys_on_entry)
    else $error("system-on without reset release");
  property p_level_off;
    state_q == PST_SYS_ON && !fault_cause && !power_on_edge_mode_in && !pon
      |=> state_q == PST_PD_TURNOFF;
  endproperty
  a_level_off: assert property (p_level_off)
    else $error("level turn-off missed");
  property p_sw_off_wait;
    state_q == PST_PD_TURNOFF && $past(state_q) == PST_SYS_ON &&
      $past(pon) && !$past(hold_exp) && !$past(ovlo_exp) |-> $past(off_exp);
  endproperty
  a_sw_off_wait: assert property (p_sw_off_wait)
    else $error("software turn-off before timer");
  property p_turnoff_done;
    state_q == PST_PD_TURNOFF && power_down_done_in |=> state_q == PST_LOW_POWER_OFF_STATE;
  endproperty
  a_turnoff_done: assert property (p_turnoff_done)
    else $error("turn-off did not reach low-power off");
  property p_fault_done;
    state_q == PST_PD_FAULT && power_down_done_in |=> state_q == PST_FS_TRANS;
  endproperty
  a_fault_done: assert property (p_fault_done)
    else $error("fault power-down did not reach fail-safe");
  property p_fs_return;
    state_q == PST_FS_TRANS &&
      (failsafe_lock_bypass_in || failsafe_event_count_q < failsafe_count_limit_in)
      |=> state_q == PST_LOW_POWER_OFF_STATE;
  endproperty
  a_fs_return: assert property (p_fs_return)
    else $error("fail-safe return missed");
  property p_fs_lock;
    state_q == PST_FS_TRANS && !failsafe_lock_bypass_in &&
      failsafe_event_count_q == failsafe_count_limit_in |=> state_q == PST_FS_LOCK [*2];
  endproperty
  a_fs_lock: assert property (p_fs_lock)
    else $error("fail-safe lock missed");
  property p_err_ignore;
    state_q == PST_QUICK_START_OFF_STATE && errs |=> state_q == PST_QUICK_START_OFF_STATE;
  endproperty
  a_err_ignore: assert property (p_err_ignore)
    else $error("power-up taken despite error flag");
  property p_st_fail;
    state_q == PST_SELF_TEST && $past(state_q) == PST_SELF_TEST &&
      state_d == PST_FS_TRANS |-> tries_q == 2'h2 && !trial;
  endproperty
  a_st_fail: assert property (p_st_fail)
    else $error("fail-safe before third self-check failure");

  c_full_cycle: cover property (state_q == PST_SYS_ON ##[1:1000]
    state_q == PST_PD_TURNOFF ##[1:1000] state_q == PST_LOW_POWER_OFF_STATE);
  c_fault_path: cover property (state_q == PST_PD_FAULT ##[1:1000]
    state_q == PST_FS_TRANS);
  c_lock: cover property (state_q == PST_FS_LOCK);
  c_retry: cover property (gap_act_q ##1 !gap_act_q && start_q);
endmodule

// ==== pst_seq_model.sv ====
`timescale 1ns/1ps
module pst_seq_model
  import pst_pkg::*;
#(
  parameter int DLY = 4
) (
  input  wire logic       clk_in,         // Design clock
  input  wire logic [8:0] state_in,       // Watched state
  input  wire logic       check_start_in, // Check start pulse
  input  wire logic       up_fail_in,     // Fail the power-up
  input  wire logic [1:0] check_fails_in, // Attempts that fail
  output logic            check_done_out, // Check finished
  output logic            check_ok_out,   // Check result
  output logic            release_out,    // Host reset released
  output logic            up_failure_out, // Power-up failure
  output logic            down_done_out,  // Power-down finished
  output int              start_cnt_out   // Starts since off
);
  logic [8:0] last_q;
  int         dwell_q;
  int         pend_q;
  int         fails_q;
  logic       ripe;
  // Stale dwell from the previous state must not fire
  assign ripe = (state_in == last_q) && (dwell_q == DLY);
  initial begin
    {check_done_out, check_ok_out, release_out} = 3'h0;
    {up_failure_out, down_done_out} = 2'h0;
    last_q = 9'h000;
    dwell_q       = 0;
    pend_q        = 0;
    fails_q       = 0;
    start_cnt_out = 0;
  end
  // Falling edge drive, so the design samples settled values
  always @(negedge clk_in) begin
    check_done_out <= 1'b0;
    check_ok_out   <= ~check_ok_out; // Junk outside the done pulse
    {release_out, up_failure_out, down_done_out} <= 3'h0;
    last_q  <= state_in;
    dwell_q <= (state_in == last_q) ? dwell_q + 1 : 0;
    if (state_in == PST_PWR_UP && ripe) begin
      release_out    <= ~up_fail_in;
      up_failure_out <= up_fail_in;
    end
    if ((state_in == PST_PD_TURNOFF || state_in == PST_PD_FAULT) && ripe)
      down_done_out <= 1'b1;
    if (state_in != PST_SELF_TEST)
      fails_q <= 0;
    if (state_in == PST_LOW_POWER_OFF_STATE)
      start_cnt_out <= 0;
    if (check_start_in) begin
      pend_q        <= DLY;
      start_cnt_out <= start_cnt_out + 1;
    end else if (pend_q > 1) begin
      pend_q <= pend_q - 1;
    end else if (pend_q == 1) begin
      pend_q         <= 0;
      check_done_out <= 1'b1;
      check_ok_out   <= fails_q >= int'(check_fails_in);
      if (fails_q < int'(check_fails_in))
        fails_q <= fails_q + 1;
    end
  end
endmodule

// ==== tb_power_state_transitions.sv ====
`timescale 1ns/1ps
module tb_power_state_transitions
  import pst_pkg::*;
();
  localparam int OFF  = 20;
  localparam int GAP  = 10;
  localparam int HOLD = 8;
  localparam int DBNC = 5;
  localparam int DLY  = 4;
  logic             clk, arst_n, pon, trial, ovlo, thermal_shutdown_limit, vin_ok, lpm;
  logic             edge_md, ov_en, trim, fuse, soft_off, ftimer;
  logic             bypass, up_fail, sc_done, sc_ok, sc_start, sc_fail;
  logic             rel, up_flr, pd_done, host_rst_n, prot;
  logic [CNT_W-1:0] fcnt, flim, fslim, failsafe_event_count;
  logic [1:0]       chk_fails;
  logic [8:0]       state;
  int               starts, error_cnt, cmp_count, cycles;

  pst_power_state_transitions #(.OFF_CYC(OFF), .GAP_CYC(GAP),
    .HOLD_CYC(HOLD), .DBNC_CYC(DBNC)) dut (
    .core_clk_in(clk), .arst_n_in(arst_n), .power_on_input_in(pon),
    .config_trial_mode_pin_in(trial), .input_overvoltage_lockout_in(ovlo),
    .thermal_shutdown_limit_in(thermal_shutdown_limit), .vin_in_window_in(vin_ok),
    .low_power_off_select_in(lpm), .power_on_edge_mode_in(edge_md),
    .overvoltage_shutdown_enable_in(ov_en), .trim_load_error_in(trim),
    .fuse_load_error_in(fuse), .software_off_request_in(soft_off),
    .fault_timer_expired_in(ftimer), .fault_event_count_in(fcnt),
    .fault_count_limit_in(flim), .failsafe_count_limit_in(fslim),
    .failsafe_lock_bypass_in(bypass), .self_check_done_in(sc_done),
    .self_check_ok_in(sc_ok), .host_reset_release_in(rel),
    .power_up_failure_in(up_flr), .power_down_done_in(pd_done),
    .state_out(state), .self_check_start_out(sc_start),
    .self_check_fail_out(sc_fail), .host_reset_output_n_out(host_rst_n),
    .failsafe_event_count_out(failsafe_event_count), .turnoff_protective_out(prot));

  pst_seq_model #(.DLY(DLY)) u_seq (.clk_in(clk), .state_in(state),
    .check_start_in(sc_start), .up_fail_in(up_fail),
    .check_fails_in(chk_fails), .check_done_out(sc_done),
    .check_ok_out(sc_ok), .release_out(rel), .up_failure_out(up_flr),
    .down_done_out(pd_done), .start_cnt_out(starts));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic test_done();
    $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Whole run is near 400 cycles
  initial cycles = 0;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [8:0] seen,
                     input logic [8:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_st(input logic [8:0] exp, input int lim);
    int n;
    n = 0;
    while (state !== exp && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk("state_out", state, exp);
  endtask
  task automatic stay(input logic [8:0] exp, input int n);
    repeat (n) begin
      @(negedge clk);
      chk("state_out", state, exp);
    end
  endtask
  task automatic hr(input logic e);
    chk("host_reset_output_n_out", {8'h00, host_rst_n}, {8'h00, e});
  endtask
  task automatic fsc(input logic [3:0] e);
    chk("failsafe_event_count_out", {5'h00, failsafe_event_count}, {5'h00, e});
  endtask
  task automatic do_reset();
    arst_n = 1'b0;
    repeat (8) @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask
  task automatic boot();
    pon = 1'b1;
    wait_st(PST_SYS_ON, 60);
  endtask

  initial begin
    {pon, trial, ovlo, thermal_shutdown_limit, lpm, edge_md, trim, fuse} = 8'h00;
    {soft_off, ftimer, bypass, up_fail} = 4'h0;
    {vin_ok, ov_en} = 2'h3;
    {fcnt, flim, fslim, chk_fails} = 14'h3c88;
    error_cnt = 0;
    cmp_count = 0;
    do_reset();
    chk("state_out", state, PST_LOW_POWER_OFF_STATE);
    hr(1'b0);
    pon = 1'b1;
    wait_st(PST_SELF_TEST, 8);
    wait_st(PST_QUICK_START_OFF_STATE, 20);
    wait_st(PST_PWR_UP, 4);
    hr(1'b0);
    wait_st(PST_SYS_ON, 10);
    hr(1'b1);
    pon = 1'b0;
    wait_st(PST_PD_TURNOFF, 5);
    hr(1'b0);
    wait_st(PST_LOW_POWER_OFF_STATE, 10);
    stay(PST_LOW_POWER_OFF_STATE, 6);
    $display("Test level power-up and turn-off done");
    boot();
    soft_off = 1'b1;
    stay(PST_SYS_ON, OFF);
    wait_st(PST_PD_TURNOFF, 2);
    {soft_off, pon} = 2'h0;
    wait_st(PST_LOW_POWER_OFF_STATE, 10);
    boot();
    ovlo = 1'b1;
    stay(PST_SYS_ON, DBNC + 3);
    wait_st(PST_PD_TURNOFF, 6);
    chk("turnoff_protective_out", {8'h00, prot}, 9'h001);
    {ovlo, pon} = 2'h0;
    wait_st(PST_LOW_POWER_OFF_STATE, 10);
    $display("Test requested turn-off causes done");
    boot();
    thermal_shutdown_limit = 1'b1;
    wait_st(PST_PD_FAULT, 5);
    chk("turnoff_protective_out", {8'h00, prot}, 9'h000);
    {thermal_shutdown_limit, pon} = 2'h0;
    wait_st(PST_FS_TRANS, 10);
    wait_st(PST_LOW_POWER_OFF_STATE, 3);
    fsc(4'h1);
    boot();
    pon = 1'b0;
    // Both causes land on the same edge: pin goes through the synchroniser
    repeat (2) @(negedge clk);
    ftimer = 1'b1;
    wait_st(PST_PD_FAULT, 3);
    ftimer = 1'b0;
    wait_st(PST_FS_TRANS, 10);
    wait_st(PST_LOW_POWER_OFF_STATE, 3);
    fsc(4'h2);
    boot();
    {fcnt, flim} = 8'h77;
    wait_st(PST_PD_FAULT, 3);
    {fcnt, flim, pon} = 9'h01e;
    wait_st(PST_FS_TRANS, 10);
    wait_st(PST_FS_LOCK, 3);
    stay(PST_FS_LOCK, 10);
    $display("Test fault paths and fail-safe done");
    do_reset();
    {fslim, bypass, up_fail, pon} = 7'h07;
    wait_st(PST_PWR_UP, 30);
    wait_st(PST_PD_FAULT, 8);
    {pon, up_fail} = 2'h0;
    wait_st(PST_FS_TRANS, 10);
    wait_st(PST_LOW_POWER_OFF_STATE, 3);
    {chk_fails, pon} = 3'h7;
    wait_st(PST_SELF_TEST, 8);
    repeat (DLY + GAP) @(negedge clk);
    chk("self_check_starts", 9'(starts), 9'h001);
    pon = 1'b0;
    wait_st(PST_FS_TRANS, 3 * (DLY + GAP) + 20);
    chk("self_check_starts", 9'(starts), 9'h003);
    chk("self_check_fail_out", {8'h00, sc_fail}, 9'h001);
    wait_st(PST_LOW_POWER_OFF_STATE, 3);
    chk_fails = 2'h0;
    $display("Test power-up failure and self-check retries done");
    do_reset();
    lpm = 1'b1;
    wait_st(PST_QUICK_START_OFF_STATE, 20);
    {trim, pon} = 2'h3;
    stay(PST_QUICK_START_OFF_STATE, 8);
    trim = 1'b0;
    wait_st(PST_PWR_UP, 5);
    wait_st(PST_SYS_ON, 10);
    edge_md = 1'b1;
    @(negedge clk);
    pon = 1'b0;
    stay(PST_SYS_ON, HOLD + 4);
    wait_st(PST_PD_TURNOFF, 6);
    wait_st(PST_QUICK_START_OFF_STATE, 30);
    pon = 1'b1;
    stay(PST_QUICK_START_OFF_STATE, 6);
    pon = 1'b0;
    wait_st(PST_PWR_UP, 5);
    wait_st(PST_SYS_ON, 10);
    {edge_md, lpm, trial} = 3'h1;
    wait_st(PST_PD_TURNOFF, 5);
    wait_st(PST_QUICK_START_OFF_STATE, 30);
    stay(PST_QUICK_START_OFF_STATE, 5);
    pon = 1'b1;
    wait_st(PST_PWR_UP, 5);
    $display("Test quick-start off entries done");
    test_done();
  end
endmodule
